// ==== src/srs_pkg.sv ====
package srs_pkg;

    localparam int DATA_W = 16;
    localparam int REG_SEL_W = 4;
    localparam int REPEAT_LIT_W = 14;
    localparam int RETURN_LIT_W = 10;
    localparam int SHIFT_LIT_W = 5;

    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [3:0] ACC_SEL = 4'h0;

    // Cycle counts per operation
    localparam int ONE_CYCLE = 1;
    localparam int RETURN_CYCLES = 3;
    localparam int RETURN_CYCLES_ALT = 2;

    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_OV = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_DC = 4;
    localparam logic [4:0] FLAGS_RESET = 5'h00;

    typedef enum logic [3:0] {
        SRS_NOP,
        SRS_POWER_SAVE,
        SRS_REPEAT,
        SRS_RETURN_LIT,
        SRS_ROT_LEFT_CARRY,
        SRS_ROT_LEFT_PLAIN,
        SRS_ROT_RIGHT_CARRY,
        SRS_ROT_RIGHT_PLAIN,
        SRS_SIGN_EXTEND,
        SRS_SHIFT_LEFT_REG,
        SRS_SHIFT_LEFT_LIT,
        SRS_MINUS_BORROW,
        SRS_REV_MINUS_BORROW,
        SRS_FILL_ONES,
        SRS_SWAP
    } srs_op_t;

    typedef struct packed {
        logic valid;
        srs_op_t op;
        logic byte_mode;
        logic use_literal;
        logic alt_timing;
        logic [15:0] operand_a;
        logic [15:0] operand_b;
        logic [13:0] literal;
        logic [3:0] dest_sel;
    } srs_req_t;

    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } srs_flags_t;

endpackage

// ==== src/srs_compute.sv ====
`timescale 1ns/1ps
// Pure combinational result and flag generation
module srs_compute (
    input wire srs_pkg::srs_req_t req,
    input wire srs_pkg::srs_flags_t flags_in,
    output logic [15:0] result,
    output srs_pkg::srs_flags_t flags_out,
    output logic writes_result
);

    function automatic logic [16:0] sub_borrow(
        input logic [15:0] x,
        input logic [15:0] y,
        input logic carry
    );
        sub_borrow = {1'b0, x} + {1'b0, ~y} + {16'h0000, carry};
    endfunction

    function automatic logic is_zero(input logic [15:0] v);
        is_zero = (v == srs_pkg::WORD_ZERO);
    endfunction

    logic [16:0] diff;
    logic [4:0] low_diff;
    logic [15:0] x_op;
    logic [15:0] y_op;
    logic [15:0] b_val;

    always_comb
    begin
        b_val = req.use_literal ? {11'h000, req.literal[4:0]} : req.operand_b;
        x_op = (req.op == srs_pkg::SRS_REV_MINUS_BORROW) ? b_val : req.operand_a;
        y_op = (req.op == srs_pkg::SRS_REV_MINUS_BORROW) ? req.operand_a : b_val;
        diff = sub_borrow(x_op, y_op, flags_in.c);
        low_diff = {1'b0, x_op[3:0]} + {1'b0, ~y_op[3:0]}
            + {4'h0, flags_in.c};
        result = req.operand_a;
        flags_out = flags_in;
        writes_result = 1'b1;
        unique case (req.op)
            srs_pkg::SRS_ROT_LEFT_CARRY:
            begin
                result = {req.operand_a[14:0], flags_in.c};
                flags_out.c = req.operand_a[15];
            end
            srs_pkg::SRS_ROT_LEFT_PLAIN:
                result = {req.operand_a[14:0], req.operand_a[15]};
            srs_pkg::SRS_ROT_RIGHT_CARRY:
            begin
                result = {flags_in.c, req.operand_a[15:1]};
                flags_out.c = req.operand_a[0];
            end
            srs_pkg::SRS_ROT_RIGHT_PLAIN:
                result = {req.operand_a[0], req.operand_a[15:1]};
            srs_pkg::SRS_SIGN_EXTEND:
            begin
                result = {{8{req.operand_a[7]}}, req.operand_a[7:0]};
                flags_out.c = ~req.operand_a[7];
            end
            srs_pkg::SRS_SHIFT_LEFT_REG:
                result = req.operand_a << req.operand_b[3:0];
            srs_pkg::SRS_SHIFT_LEFT_LIT:
                result = (req.literal[4]) ? srs_pkg::WORD_ZERO
                    : req.operand_a << req.literal[3:0];
            srs_pkg::SRS_MINUS_BORROW, srs_pkg::SRS_REV_MINUS_BORROW:
            begin
                result = diff[15:0];
                flags_out.c = diff[16];
                flags_out.dc = low_diff[4];
                flags_out.ov = (x_op[15] != y_op[15])
                    && (diff[15] != x_op[15]);
            end
            srs_pkg::SRS_FILL_ONES:
                result = srs_pkg::ALL_ONES;
            srs_pkg::SRS_SWAP:
                result = req.byte_mode
                    ? {req.operand_a[15:8], req.operand_a[3:0],
                       req.operand_a[7:4]}
                    : {req.operand_a[7:0], req.operand_a[15:8]};
            srs_pkg::SRS_RETURN_LIT:
                result = {6'h00, req.literal[9:0]};
            default:
                writes_result = 1'b0;
        endcase
        unique case (req.op)
            srs_pkg::SRS_ROT_LEFT_CARRY, srs_pkg::SRS_ROT_LEFT_PLAIN,
            srs_pkg::SRS_ROT_RIGHT_CARRY, srs_pkg::SRS_ROT_RIGHT_PLAIN,
            srs_pkg::SRS_SIGN_EXTEND, srs_pkg::SRS_SHIFT_LEFT_REG,
            srs_pkg::SRS_SHIFT_LEFT_LIT, srs_pkg::SRS_MINUS_BORROW,
            srs_pkg::SRS_REV_MINUS_BORROW:
            begin
                flags_out.n = result[15];
                flags_out.z = is_zero(result);
            end
            default:
                flags_out.n = flags_in.n;
        endcase
    end

endmodule

// ==== src/srs_alu.sv ====
`timescale 1ns/1ps
module srs_alu #(
    parameter int REPEAT_W = srs_pkg::REPEAT_LIT_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire srs_pkg::srs_req_t req,
    input wire logic wdt_timeout_event,
    output logic req_ready,
    output logic result_valid,
    output logic [15:0] result_data,
    output logic [3:0] result_dest,
    output srs_pkg::srs_flags_t status_flags,
    output logic [REPEAT_W-1:0] repeat_remaining,
    output logic repeat_active,
    output logic return_pulse,
    output logic sleep_mode,
    output logic idle_mode,
    output logic watchdog_timeout_flag,
    output logic sleep_flag
);

    typedef enum logic [1:0] {
        SRS_IDLE_ST,
        SRS_RET_WAIT,
        SRS_SAVED
    } srs_state_t;

    srs_state_t state_reg;
    logic [1:0] wait_reg;
    logic [15:0] alu_result;
    srs_pkg::srs_flags_t alu_flags;
    logic alu_writes;
    logic take;
    logic take_repeatable;

    srs_compute u_compute (
        .req(req),
        .flags_in(status_flags),
        .result(alu_result),
        .flags_out(alu_flags),
        .writes_result(alu_writes)
    );

    // A new request is accepted only while not in a multi-cycle return
    // and not powered down; the decoder must hold req until then.
    assign take = req.valid && (state_reg == SRS_IDLE_ST);
    assign take_repeatable = take
        && (req.op != srs_pkg::SRS_REPEAT)
        && (req.op != srs_pkg::SRS_POWER_SAVE)
        && (req.op != srs_pkg::SRS_RETURN_LIT);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= SRS_IDLE_ST;
            wait_reg <= 2'h0;
            req_ready <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                SRS_IDLE_ST:
                    if (take && req.op == srs_pkg::SRS_RETURN_LIT)
                    begin
                        state_reg <= SRS_RET_WAIT;
                        req_ready <= 1'b0;
                        wait_reg <= req.alt_timing
                            ? 2'(srs_pkg::RETURN_CYCLES_ALT - 2)
                            : 2'(srs_pkg::RETURN_CYCLES - 2);
                    end
                    else if (take && req.op == srs_pkg::SRS_POWER_SAVE)
                    begin
                        state_reg <= SRS_SAVED;
                        req_ready <= 1'b0;
                    end
                SRS_RET_WAIT:
                    if (wait_reg == 2'h0)
                    begin
                        state_reg <= SRS_IDLE_ST;
                        req_ready <= 1'b1;
                    end
                    else
                    begin
                        wait_reg <= wait_reg - 2'h1;
                    end
                SRS_SAVED:
                    // Only a watchdog timeout wakes the core here
                    if (wdt_timeout_event)
                    begin
                        state_reg <= SRS_IDLE_ST;
                        req_ready <= 1'b1;
                    end
                default:
                    state_reg <= SRS_IDLE_ST;
            endcase
        end
    end

    // Result writeback, one cycle after the request
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            result_valid <= 1'b0;
            result_data <= srs_pkg::WORD_ZERO;
            result_dest <= srs_pkg::ACC_SEL;
            return_pulse <= 1'b0;
        end
        else
        begin
            result_valid <= take && alu_writes;
            return_pulse <= take
                && (req.op == srs_pkg::SRS_RETURN_LIT);
            if (take && alu_writes)
            begin
                result_data <= alu_result;
                result_dest <= req.dest_sel;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            status_flags <= srs_pkg::FLAGS_RESET;
        else if (take)
            status_flags <= alu_flags;
    end

    // Repeat counter: next instruction runs count + 1 times
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            repeat_remaining <= '0;
            repeat_active <= 1'b0;
        end
        else if (take && req.op == srs_pkg::SRS_REPEAT)
        begin
            repeat_active <= 1'b1;
            repeat_remaining <= req.use_literal
                ? REPEAT_W'(req.literal)
                : REPEAT_W'(req.operand_a);
        end
        else if (take_repeatable && repeat_active)
        begin
            if (repeat_remaining == '0)
                repeat_active <= 1'b0;
            else
                repeat_remaining <= repeat_remaining - REPEAT_W'(1);
        end
    end

    // Power-save mode and status flags; hardware set wins over clear
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sleep_mode <= 1'b0;
            idle_mode <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            sleep_flag <= 1'b0;
        end
        else if (take && req.op == srs_pkg::SRS_POWER_SAVE)
        begin
            sleep_mode <= ~req.literal[0];
            idle_mode <= req.literal[0];
            sleep_flag <= ~req.literal[0];
            watchdog_timeout_flag <= wdt_timeout_event;
        end
        else if (state_reg == SRS_SAVED && wdt_timeout_event)
        begin
            sleep_mode <= 1'b0;
            idle_mode <= 1'b0;
            watchdog_timeout_flag <= 1'b1;
        end
    end

endmodule

// ==== tb/srs_alu_chk.sv ====
`timescale 1ns/1ps
module srs_alu_chk #(
    parameter int REPEAT_W = 14
) (
    input wire logic clock,
    input wire logic resetn,
    input wire srs_pkg::srs_req_t req,
    input wire logic req_ready,
    input wire logic result_valid,
    input wire logic [15:0] result_data,
    input wire srs_pkg::srs_flags_t status_flags,
    input wire logic [REPEAT_W-1:0] repeat_remaining,
    input wire logic repeat_active,
    input wire logic return_pulse,
    input wire logic sleep_mode,
    input wire logic sleep_flag
);
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic tk;
    logic [15:0] a_q;
    logic c_q;
    logic [REPEAT_W-1:0] l_q;
    assign tk = req.valid && req_ready;
    // Operands of the taken request, for comparison one cycle on
    always_ff @(posedge clock)
    begin
        a_q <= req.operand_a;
        c_q <= status_flags.c;
        l_q <= REPEAT_W'(req.literal);
    end
    sequence ready_gap_two;
        !req_ready [*2] ##1 req_ready;
    endsequence
    chk_return_wait: assert property (
        tk && req.op == srs_pkg::SRS_RETURN_LIT && !req.alt_timing
        |=> return_pulse ##0 ready_gap_two) else $error("return wait");
    chk_rot_lc: assert property (
        tk && req.op == srs_pkg::SRS_ROT_LEFT_CARRY |=> result_valid &&
        result_data == {a_q[14:0], c_q} && status_flags.c == a_q[15])
        else $error("rotate left carry");
    chk_rot_lp: assert property (
        tk && req.op == srs_pkg::SRS_ROT_LEFT_PLAIN |=> result_valid &&
        result_data == {a_q[14:0], a_q[15]} && status_flags.c == c_q)
        else $error("rotate left plain");
    chk_rot_rc: assert property (
        tk && req.op == srs_pkg::SRS_ROT_RIGHT_CARRY |=>
        result_data == {c_q, a_q[15:1]} && status_flags.c == a_q[0])
        else $error("rotate right carry");
    chk_rot_rp: assert property (
        tk && req.op == srs_pkg::SRS_ROT_RIGHT_PLAIN |=>
        result_data == {a_q[0], a_q[15:1]} && $stable(status_flags.c))
        else $error("rotate right plain");
    chk_sign_ext: assert property (
        tk && req.op == srs_pkg::SRS_SIGN_EXTEND |=>
        result_data == {{8{a_q[7]}}, a_q[7:0]} && status_flags.n == a_q[7])
        else $error("sign extend");
    chk_repeat_load: assert property (
        tk && req.op == srs_pkg::SRS_REPEAT && req.use_literal |=>
        repeat_active && repeat_remaining == l_q) else $error("repeat");
    chk_sleep_entry: assert property (
        tk && req.op == srs_pkg::SRS_POWER_SAVE && !req.literal[0] |=>
        sleep_mode && sleep_flag && !req_ready) else $error("sleep entry");
endmodule

// ==== tb/srs_dec_model.sv ====
`timescale 1ns/1ps
module srs_dec_model (
    input wire logic clock,
    input wire logic req_ready,
    output srs_pkg::srs_req_t req
);
    initial req = '0;
    // Entered at a falling edge; held to the rising edge that takes it
    task automatic issue(input srs_pkg::srs_req_t r);
        srs_pkg::srs_req_t t;
        logic ok;
        // Built locally so the port changes once per time step
        t = r;
        t.valid = 1'b1;
        req = t;
        ok = req_ready;
        while (!ok)
        begin
            @(negedge clock);
            ok = req_ready;
        end
        @(posedge clock);
    endtask
    // Stale operands are inverted so nothing leans on old values
    task automatic drop();
        srs_pkg::srs_req_t t;
        t = req;
        t.valid = 1'b0;
        t.operand_a = ~t.operand_a;
        t.operand_b = ~t.operand_b;
        req = t;
    endtask
endmodule

// ==== tb/srs_alu_test.sv ====
`timescale 1ns/1ps
module srs_alu_test;
    localparam int REPEAT_W = 14;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wdt_timeout_event = 1'b0;
    srs_pkg::srs_req_t req;
    logic req_ready, result_valid, return_pulse, repeat_active;
    logic [15:0] result_data;
    logic [3:0] result_dest;
    srs_pkg::srs_flags_t status_flags, fl;
    logic [REPEAT_W-1:0] repeat_remaining;
    logic sleep_mode, idle_mode, watchdog_timeout_flag, sleep_flag;
    int err_total = 0;
    int tests_run = 0;
    always #20 clock = ~clock;
    srs_alu #(.REPEAT_W(REPEAT_W)) uut (.clock, .resetn, .req,
        .wdt_timeout_event, .req_ready, .result_valid, .result_data,
        .result_dest, .status_flags, .repeat_remaining, .repeat_active,
        .return_pulse, .sleep_mode, .idle_mode, .watchdog_timeout_flag,
        .sleep_flag);
    srs_dec_model dec (.clock, .req_ready, .req);
    task automatic check(input string what, input logic [20:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [20:0] calc(srs_pkg::srs_req_t r,
        srs_pkg::srs_flags_t f);
        logic [15:0] a, b, y;
        logic [16:0] d;
        logic [4:0] h;
        a = r.operand_a;
        b = r.use_literal ? {11'h000, r.literal[4:0]} : r.operand_b;
        if (r.op == srs_pkg::SRS_REV_MINUS_BORROW)
            {a, b} = {b, a};
        d = {1'b0, a} - {1'b0, b} - 17'(!f.c);
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(!f.c);
        case (r.op)
            srs_pkg::SRS_RETURN_LIT: y = {6'h00, r.literal[9:0]};
            srs_pkg::SRS_ROT_LEFT_CARRY: {f.c, y} = {a, f.c};
            srs_pkg::SRS_ROT_LEFT_PLAIN: y = {a[14:0], a[15]};
            srs_pkg::SRS_ROT_RIGHT_CARRY: {y, f.c} = {f.c, a};
            srs_pkg::SRS_ROT_RIGHT_PLAIN: y = {a[0], a[15:1]};
            srs_pkg::SRS_SIGN_EXTEND: {f.c, y} = {!a[7], {8{a[7]}}, a[7:0]};
            srs_pkg::SRS_SHIFT_LEFT_REG: y = a << r.operand_b[3:0];
            srs_pkg::SRS_SHIFT_LEFT_LIT: y = a << r.literal[4:0];
            srs_pkg::SRS_MINUS_BORROW, srs_pkg::SRS_REV_MINUS_BORROW:
            begin
                y = d[15:0];
                f.c = !d[16];
                f.dc = !h[4];
                f.ov = (a[15] != b[15]) && (y[15] != a[15]);
            end
            srs_pkg::SRS_FILL_ONES: y = 16'hFFFF;
            srs_pkg::SRS_SWAP: y = r.byte_mode ? {a[15:8], a[3:0], a[7:4]}
                : {a[7:0], a[15:8]};
            default: y = a;
        endcase
        // Only rotates, sign extend, shifts and subtracts touch N and Z
        if (r.op inside {[srs_pkg::SRS_ROT_LEFT_CARRY:
            srs_pkg::SRS_REV_MINUS_BORROW]})
            {f.n, f.z} = {y[15], y == 16'h0000};
        return {f, y};
    endfunction
    task automatic go(input srs_pkg::srs_req_t r);
        logic [20:0] e;
        logic [20:0] s;
        e = calc(r, fl);
        fl = e[20:16];
        dec.issue(r);
        @(negedge clock);
        s = {result_valid, result_dest, result_data};
        if (!(r.op inside {srs_pkg::SRS_POWER_SAVE, srs_pkg::SRS_REPEAT}))
            check("result", s, {1'b1, r.dest_sel, e[15:0]});
        check("flags", 21'(status_flags), 21'(fl));
        if (r.op == srs_pkg::SRS_RETURN_LIT)
            check("return", 21'({return_pulse, req_ready}), 21'h2);
    endtask
    initial
    begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        srs_pkg::srs_req_t r;
        int n;
        void'($urandom(32'h560E));
        fl = '0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 80; i++)
        begin
            r = $bits(r)'({$urandom, $urandom});
            r.op = srs_pkg::srs_op_t'(4'($urandom_range(3, 14)));
            go(r);
        end
        $display("test random burst done");
        for (int u = 0; u < 2; u++)
        begin
            n = $urandom_range(1, 5);
            r = $bits(r)'({$urandom, $urandom});
            {r.op, r.use_literal} = {srs_pkg::SRS_REPEAT, u[0]};
            {r.literal, r.operand_a} = {14'(n), 16'(n)};
            go(r);
            check("remaining", 21'(repeat_remaining), 21'(n));
            r.op = srs_pkg::SRS_ROT_LEFT_PLAIN;
            for (int k = 0; k <= n; k++)
            begin
                go(r);
                check("active", 21'(repeat_active), 21'(k < n));
            end
        end
        $display("test repeat done");
        for (int m = 0; m < 2; m++)
        begin
            r.op = srs_pkg::SRS_POWER_SAVE;
            r.literal[0] = m[0];
            go(r);
            check("enter", 21'({sleep_mode, idle_mode, req_ready,
                sleep_flag | m[0]}), 21'({!m[0], m[0], 2'b01}));
            dec.drop();
            repeat (3) @(negedge clock);
            wdt_timeout_event = 1'b1;
            @(negedge clock);
            wdt_timeout_event = 1'b0;
            for (int w = 0; w < 4 && !req_ready; w++)
                @(negedge clock);
            check("wake", 21'({sleep_mode, idle_mode, req_ready,
                watchdog_timeout_flag}), 21'h3);
        end
        $display("test power save done");
        print_verdict();
    end
endmodule
bind srs_alu srs_alu_chk #(.REPEAT_W(REPEAT_W)) chk (.clock, .resetn, .req,
    .req_ready, .result_valid, .result_data, .status_flags,
    .repeat_remaining, .repeat_active, .return_pulse, .sleep_mode,
    .sleep_flag);
